// ==== src/adcc_map.svh ====
`ifndef ADCC_MAP_SVH
`define ADCC_MAP_SVH

// Register pointer values
`define ADCC_PTR_RESULT 8'h00
`define ADCC_PTR_SETUP 8'h01

// Setup register layout and reset value
`define ADCC_SETUP_RESET 16'h8583
`define ADCC_TRIG_BIT 15
`define ADCC_SEL_HI 14
`define ADCC_SEL_LO 12
`define ADCC_ONESHOT_BIT 8

// Bus addressing
`define ADCC_BUS_ADDR_BASE 7'h48
`define ADCC_GCALL_ADDR 8'h00
`define ADCC_GCALL_RESET 8'h06

// Result clip codes
`define ADCC_RESULT_MAX 16'h7FFF
`define ADCC_RESULT_MIN 16'h8000

// Timing: conversion time in us, cycle count derived from the clock period
`define ADCC_CLK_PERIOD_NS 25
`define ADCC_CONV_TIME_US 1200
`define ADCC_CONV_CYCLES ((`ADCC_CONV_TIME_US * 1000 + `ADCC_CLK_PERIOD_NS - 1) / `ADCC_CLK_PERIOD_NS)

`endif

// ==== src/adcc_pkg.sv ====
package adcc_pkg;

  // Serial slave sequencer states
  typedef enum logic [2:0] {
    ADCC_ST_IDLE,
    ADCC_ST_RX,
    ADCC_ST_RX_ACK,
    ADCC_ST_TX,
    ADCC_ST_TX_ACK,
    ADCC_ST_IGNORE
  } adcc_bus_st_t;

  // Conversion engine states
  typedef enum logic {
    ADCC_CV_OFF,
    ADCC_CV_RUN
  } adcc_conv_st_t;

  // Input selector codes
  typedef enum logic [2:0] {
    ADCC_SEL_0_1,
    ADCC_SEL_0_3,
    ADCC_SEL_1_3,
    ADCC_SEL_2_3,
    ADCC_SEL_0_G,
    ADCC_SEL_1_G,
    ADCC_SEL_2_G,
    ADCC_SEL_3_G
  } adcc_sel_t;

endpackage

// ==== src/adcc_conv_if.sv ====
`timescale 1ns/10ps

interface adcc_conv_if;
  logic start;
  logic cont;
  logic abort;
  logic busy;
  logic [15:0] result;

  modport ctrl (output start, output cont, output abort, input busy, input result);
  modport eng (input start, input cont, input abort, output busy, output result);
endinterface

// ==== src/adcc_conv_engine.sv ====
`timescale 1ns/10ps
`include "adcc_map.svh"

module adcc_conv_engine
  import adcc_pkg::*;
#(
  parameter int CONV_CYCLES = 48000
) (
  // Clock and reset
  input wire logic i_core_clk,
  input wire logic i_rst_b,
  // Control side
  adcc_conv_if.eng cv,
  // Raw modulator/filter output, wider than the result
  input wire logic signed [17:0] i_conv_raw
);

  localparam int CW = $clog2(CONV_CYCLES) + 1;
  localparam logic [CW-1:0] LAST = CW'(CONV_CYCLES - 1);

  adcc_conv_st_t st_q, st_d;
  logic [CW-1:0] cnt_q, cnt_d;
  logic [15:0] res_q, res_d;

  // Saturate the wide filter word to 16-bit two's complement
  function automatic logic [15:0] clip(input logic signed [17:0] raw);
    logic [15:0] c;
    c = raw[15:0];
    if (raw > 18'sd32767) begin
      c = `ADCC_RESULT_MAX;
    end else if (raw < -18'sd32768) begin
      c = `ADCC_RESULT_MIN;
    end
    return c;
  endfunction

  // Sequencer next state
  always_comb begin
    st_d = st_q;
    cnt_d = cnt_q;
    res_d = res_q;
    if (cv.abort) begin
      st_d = ADCC_CV_OFF;
      cnt_d = '0;
      res_d = '0;
    end else begin
      unique case (st_q)
        ADCC_CV_OFF: begin
          if (cv.start || cv.cont) begin
            st_d = ADCC_CV_RUN;
            cnt_d = '0;
          end
        end
        ADCC_CV_RUN: begin
          if (cnt_q == LAST) begin
            res_d = clip(i_conv_raw);
            cnt_d = '0;
            if (!cv.cont) begin
              st_d = ADCC_CV_OFF;
            end
          end else begin
            cnt_d = cnt_q + 1'b1;
          end
        end
      endcase
    end
  end

  // Sequencer registers
  always_ff @(posedge i_core_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      st_q <= ADCC_CV_OFF;
      cnt_q <= '0;
      res_q <= '0;
    end else begin
      st_q <= st_d;
      cnt_q <= cnt_d;
      res_q <= res_d;
    end
  end

  assign cv.busy = (st_q == ADCC_CV_RUN);
  assign cv.result = res_q;

endmodule

// ==== src/adcc_input_mux.sv ====
`timescale 1ns/10ps

module adcc_input_mux
  import adcc_pkg::*;
(
  // Clock and reset
  input wire logic i_core_clk,
  input wire logic i_rst_b,
  // Selector field
  input wire logic [2:0] i_sel,
  // Switch controls
  output logic [1:0] o_pos_input,
  output logic [1:0] o_neg_input,
  output logic o_neg_ground
);

  logic [1:0] pos_q, pos_d;
  logic [1:0] neg_q, neg_d;
  logic gnd_q, gnd_d;

  // Decode selector into switch settings
  always_comb begin
    pos_d = 2'h0;
    neg_d = 2'h1;
    gnd_d = 1'b0;
    unique case (adcc_sel_t'(i_sel))
      ADCC_SEL_0_1: begin
        pos_d = 2'h0;
        neg_d = 2'h1;
      end
      ADCC_SEL_0_3: begin
        pos_d = 2'h0;
        neg_d = 2'h3;
      end
      ADCC_SEL_1_3: begin
        pos_d = 2'h1;
        neg_d = 2'h3;
      end
      ADCC_SEL_2_3: begin
        pos_d = 2'h2;
        neg_d = 2'h3;
      end
      ADCC_SEL_0_G, ADCC_SEL_1_G, ADCC_SEL_2_G, ADCC_SEL_3_G: begin
        pos_d = i_sel[1:0];
        neg_d = 2'h0;
        gnd_d = 1'b1;
      end
    endcase
  end

  // Registered switch drive, no glitches on the analog side
  always_ff @(posedge i_core_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      pos_q <= 2'h0;
      neg_q <= 2'h1;
      gnd_q <= 1'b0;
    end else begin
      pos_q <= pos_d;
      neg_q <= neg_d;
      gnd_q <= gnd_d;
    end
  end

  assign o_pos_input = pos_q;
  assign o_neg_input = neg_q;
  assign o_neg_ground = gnd_q;

endmodule

// ==== src/adcc_top.sv ====
// Summary of operation
// - single-shot: one conversion, then power down
// - continuous: restart right after each conversion
// - result read anytime, always complete
// - master clocks SCL, device only senses
// - first byte: address plus direction bit
// - write pointer byte selects register
// - two data bytes load, MSB first
// - pointer-only write just moves pointer
// - read returns pointed word, MSB first
// - selector field, single-ended grounds negative
// - four singles, four pairs: 0-1, and 0, 1, 2 versus input 3
// - trigger bit starts in single-shot only, reads busy state
// - general call reset restores defaults
// - two's complement result, clipped at extremes
`timescale 1ns/10ps
`include "adcc_map.svh"

module adcc_top
  import adcc_pkg::*;
#(
  parameter int CONV_CYCLES = `ADCC_CONV_CYCLES
) (
  // Clock and reset
  input wire logic i_core_clk,
  input wire logic i_rst_b,
  // Serial bus
  input wire logic i_scl,
  input wire logic i_sda,
  output logic o_sda_out,
  output logic o_sda_oe,
  // Address select pins
  input wire logic [1:0] i_addr_sel,
  // Converter core
  input wire logic signed [17:0] i_conv_raw,
  output logic o_conv_run,
  // Input selector switches
  output logic [1:0] o_pos_input,
  output logic [1:0] o_neg_input,
  output logic o_neg_ground
);

  adcc_conv_if cv ();

  // Bus sequencer state
  adcc_bus_st_t st_q, st_d;
  logic scl_q, scl_p, sda_q, sda_p;
  logic [3:0] cnt_q, cnt_d;
  logic [2:0] idx_q, idx_d;
  logic [7:0] sh_q, sh_d;
  logic rw_q, rw_d;
  logic gc_q, gc_d;
  logic oe_q, oe_d;
  logic mack_q, mack_d;
  logic ptr_q, ptr_d;
  logic [7:0] msb_q, msb_d;
  logic [15:0] rd_q, rd_d;
  logic wr_q, wr_d;
  logic [15:0] wdat_q, wdat_d;
  logic srst_q, srst_d;
  logic sda_out_q;

  // Setup register state
  logic [15:0] setup_q, setup_d;
  logic trig_q, trig_d;
  logic run_q;

  // Bus events
  logic scl_rise, scl_fall, bus_start, bus_stop;
  logic [6:0] own_addr;
  logic [15:0] setup_view;

  // Pin samples; inputs are synchronous, one stage gives edges
  always_ff @(posedge i_core_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      scl_q <= 1'b1;
      scl_p <= 1'b1;
      sda_q <= 1'b1;
      sda_p <= 1'b1;
    end else begin
      scl_q <= i_scl;
      scl_p <= scl_q;
      sda_q <= i_sda;
      sda_p <= sda_q;
    end
  end

  // Edge and frame detection
  assign scl_rise = scl_q & ~scl_p;
  assign scl_fall = ~scl_q & scl_p;
  assign bus_start = scl_q & scl_p & sda_p & ~sda_q;
  assign bus_stop = scl_q & scl_p & ~sda_p & sda_q;

  // Address pins pick one of four slots
  assign own_addr = `ADCC_BUS_ADDR_BASE | {5'h00, i_addr_sel};

  assign setup_view = {~cv.busy, setup_q[14:0]};

  // Serial slave sequencer
  always_comb begin
    logic [2:0] nidx;
    nidx = idx_q + 3'h1;
    st_d = st_q;
    cnt_d = cnt_q;
    idx_d = idx_q;
    sh_d = sh_q;
    rw_d = rw_q;
    gc_d = gc_q;
    oe_d = oe_q;
    mack_d = mack_q;
    ptr_d = ptr_q;
    msb_d = msb_q;
    rd_d = rd_q;
    wr_d = 1'b0;
    wdat_d = wdat_q;
    srst_d = 1'b0;
    if (bus_start) begin
      // Repeated start reopens at the address byte
      st_d = ADCC_ST_RX;
      cnt_d = 4'h0;
      idx_d = 3'h0;
      gc_d = 1'b0;
      oe_d = 1'b0;
    end else if (bus_stop) begin
      st_d = ADCC_ST_IDLE;
      oe_d = 1'b0;
    end else begin
      unique case (st_q)
        ADCC_ST_IDLE, ADCC_ST_IGNORE: begin
          oe_d = 1'b0;
        end
        ADCC_ST_RX: begin
          if (scl_rise) begin
            sh_d = {sh_q[6:0], sda_q};
            cnt_d = cnt_q + 4'h1;
          end else if (scl_fall && cnt_q == 4'h8) begin
            cnt_d = 4'h0;
            // Saturate so a long write never wraps back to the address slot
            idx_d = (idx_q == 3'h4) ? idx_q : nidx;
            st_d = ADCC_ST_RX_ACK;
            oe_d = 1'b1;
            if (idx_q == 3'h0) begin
              rw_d = sh_q[0];
              rd_d = ptr_q ? setup_view : cv.result;
              if (sh_q == `ADCC_GCALL_ADDR) begin
                gc_d = 1'b1;
              end else if (sh_q[7:1] != own_addr) begin
                st_d = ADCC_ST_IGNORE;
                oe_d = 1'b0;
              end
            end else if (gc_q) begin
              if (sh_q == `ADCC_GCALL_RESET) begin
                srst_d = 1'b1;
                ptr_d = 1'b0;
              end else begin
                st_d = ADCC_ST_IGNORE;
                oe_d = 1'b0;
              end
            end else if (idx_q == 3'h1) begin
              ptr_d = (sh_q == `ADCC_PTR_SETUP);
            end else if (idx_q == 3'h2) begin
              msb_d = sh_q;
            end else if (idx_q == 3'h3) begin
              wr_d = ptr_q;
              wdat_d = {msb_q, sh_q};
            end
          end
        end
        ADCC_ST_RX_ACK: begin
          if (scl_fall) begin
            oe_d = 1'b0;
            if (rw_q && !gc_q) begin
              st_d = ADCC_ST_TX;
              sh_d = idx_q[0] ? rd_q[15:8] : rd_q[7:0];
              oe_d = idx_q[0] ? ~rd_q[15] : ~rd_q[7];
            end else begin
              st_d = ADCC_ST_RX;
            end
          end
        end
        ADCC_ST_TX: begin
          if (scl_fall) begin
            if (cnt_q == 4'h7) begin
              cnt_d = 4'h0;
              oe_d = 1'b0;
              st_d = ADCC_ST_TX_ACK;
            end else begin
              cnt_d = cnt_q + 4'h1;
              sh_d = {sh_q[6:0], 1'b0};
              oe_d = ~sh_q[6];
            end
          end
        end
        ADCC_ST_TX_ACK: begin
          if (scl_rise) begin
            mack_d = ~sda_q;
          end else if (scl_fall) begin
            if (mack_q) begin
              idx_d = nidx;
              st_d = ADCC_ST_TX;
              sh_d = nidx[0] ? rd_q[15:8] : rd_q[7:0];
              oe_d = nidx[0] ? ~rd_q[15] : ~rd_q[7];
            end else begin
              st_d = ADCC_ST_IGNORE;
            end
          end
        end
      endcase
    end
  end

  // Serial slave registers
  always_ff @(posedge i_core_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      st_q <= ADCC_ST_IDLE;
      cnt_q <= 4'h0;
      idx_q <= 3'h0;
      sh_q <= 8'h00;
      rw_q <= 1'b0;
      gc_q <= 1'b0;
      oe_q <= 1'b0;
      mack_q <= 1'b0;
      ptr_q <= 1'b0;
      msb_q <= 8'h00;
      rd_q <= 16'h0000;
      wr_q <= 1'b0;
      wdat_q <= 16'h0000;
      srst_q <= 1'b0;
      sda_out_q <= 1'b0;
    end else begin
      st_q <= st_d;
      cnt_q <= cnt_d;
      idx_q <= idx_d;
      sh_q <= sh_d;
      rw_q <= rw_d;
      gc_q <= gc_d;
      oe_q <= oe_d;
      mack_q <= mack_d;
      ptr_q <= ptr_d;
      msb_q <= msb_d;
      rd_q <= rd_d;
      wr_q <= wr_d;
      wdat_q <= wdat_d;
      srst_q <= srst_d;
      sda_out_q <= 1'b0;
    end
  end

  // Setup register and trigger
  always_comb begin
    setup_d = setup_q;
    trig_d = 1'b0;
    if (srst_q) begin
      setup_d = `ADCC_SETUP_RESET;
    end else if (wr_q) begin
      setup_d = wdat_q;
      trig_d = wdat_q[`ADCC_TRIG_BIT] & wdat_q[`ADCC_ONESHOT_BIT];
    end
  end

  // Setup registers
  always_ff @(posedge i_core_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      setup_q <= `ADCC_SETUP_RESET;
      trig_q <= 1'b0;
      run_q <= 1'b0;
    end else begin
      setup_q <= setup_d;
      trig_q <= trig_d;
      run_q <= cv.busy;
    end
  end

  // Engine control; a soft reset also aborts a running conversion
  assign cv.start = trig_q;
  assign cv.cont = ~setup_q[`ADCC_ONESHOT_BIT] & ~srst_q;
  assign cv.abort = srst_q;

  adcc_conv_engine #(
    .CONV_CYCLES(CONV_CYCLES)
  ) u_engine (
    .i_core_clk(i_core_clk),
    .i_rst_b(i_rst_b),
    .cv(cv),
    .i_conv_raw(i_conv_raw)
  );

  adcc_input_mux u_mux (
    .i_core_clk(i_core_clk),
    .i_rst_b(i_rst_b),
    .i_sel(setup_q[`ADCC_SEL_HI:`ADCC_SEL_LO]),
    .o_pos_input(o_pos_input),
    .o_neg_input(o_neg_input),
    .o_neg_ground(o_neg_ground)
  );

  assign o_sda_out = sda_out_q;
  assign o_sda_oe = oe_q;
  assign o_conv_run = run_q;

endmodule

// ==== testbench/adcc_chk_sva.sv ====
`timescale 1ns/10ps
module adcc_chk #(
  parameter int CONV_CYCLES = 400
) (
  input wire logic i_core_clk,
  input wire logic i_rst_b,
  input wire logic i_scl,
  input wire logic o_sda_out,
  input wire logic o_sda_oe,
  input wire logic o_conv_run,
  input wire logic [1:0] o_pos_input,
  input wire logic [1:0] o_neg_input,
  input wire logic o_neg_ground
);
  int run_cnt_q;
  default clocking @(posedge i_core_clk); endclocking
  default disable iff (!i_rst_b);
  // Length of the current run streak, so whole conversions can be counted
  always_ff @(posedge i_core_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      run_cnt_q <= 0;
    end else begin
      run_cnt_q <= o_conv_run ? run_cnt_q + 1 : 0;
    end
  end
  chk_sda_open_drain: assert property (o_sda_out == 1'b0)
    else $error("data pin driven high");
  chk_run_whole: assert property ($fell(o_conv_run) |-> run_cnt_q != 0 && run_cnt_q % CONV_CYCLES == 0)
    else $error("run not a whole number of conversions");
  chk_run_min: assert property ($rose(o_conv_run) |-> o_conv_run [*8])
    else $error("run too short");
  chk_gnd_neg: assert property (o_neg_ground |-> o_neg_input == 2'h0)
    else $error("grounded negative input not parked");
  chk_pair_legal: assert property (!o_neg_ground |-> (o_pos_input == 2'h0 && o_neg_input inside {2'h1, 2'h3})
    || (o_neg_input == 2'h3 && o_pos_input inside {2'h1, 2'h2}))
    else $error("illegal input pair");
  chk_sda_scl_high: assert property (i_scl && $past(i_scl) |-> $stable(o_sda_oe))
    else $error("data changed while clock high");
  chk_ack_scl_low: assert property ($rose(o_sda_oe) |-> !i_scl)
    else $error("data pulled while clock high");
  chk_rst_defaults: assert property ($rose(i_rst_b) |-> o_pos_input == 2'h0 && o_neg_input == 2'h1
    && !o_neg_ground && !o_conv_run)
    else $error("outputs not at defaults after reset");
  cover property ($fell(o_conv_run));
  cover property ($rose(o_sda_oe));
  cover property (o_neg_ground);
endmodule

bind adcc_top adcc_chk #(.CONV_CYCLES(CONV_CYCLES)) u_chk (.i_core_clk(i_core_clk), .i_rst_b(i_rst_b),
  .i_scl(i_scl), .o_sda_out(o_sda_out), .o_sda_oe(o_sda_oe), .o_conv_run(o_conv_run),
  .o_pos_input(o_pos_input), .o_neg_input(o_neg_input), .o_neg_ground(o_neg_ground));

// ==== testbench/adcc_i2c_master.sv ====
`timescale 1ns/10ps
module adcc_i2c_master (
  input wire logic i_core_clk,
  input wire logic i_sda,
  output logic o_scl,
  output logic o_sda_low
);
  // Bus idles released
  initial begin
    o_scl = 1'b1;
    o_sda_low = 1'b0;
  end
  // Phase of 8 clocks, well above the 3 clock minimum
  task automatic hp();
    repeat (8) @(negedge i_core_clk);
  endtask
  task automatic start();
    o_sda_low = 1'b1;
    hp();
    o_scl = 1'b0;
  endtask
  task automatic bit_io(input logic b, output logic r);
    o_sda_low = !b;
    hp();
    o_scl = 1'b1;
    hp();
    r = i_sda;
    o_scl = 1'b0;
  endtask
  // byte MSB first, then acknowledge slot
  task automatic byte_io(input logic [7:0] w, input logic ack_m, output logic [7:0] r, output logic ack);
    for (int i = 7; i >= 0; i--) begin
      bit_io(w[i], r[i]);
    end
    bit_io(ack_m, ack);
  endtask
  task automatic stop();
    o_sda_low = 1'b1;
    hp();
    o_scl = 1'b1;
    hp();
    o_sda_low = 1'b0;
    hp();
  endtask
endmodule

// ==== testbench/adcc_top_test.sv ====
`timescale 1ns/10ps
module adcc_top_test;
  localparam int CONV = 2000;
  logic clk, rst_b, scl, sda_low, sda_out, sda_oe, run, gnd;
  logic [1:0] addr_sel, pos, neg;
  logic signed [17:0] raw;
  wire sda;
  int num_errors = 0;
  int compares = 0;
  int cyc = 0;
  // Pulled-up wire: low if either party pulls
  assign sda = !(sda_oe === 1'b1 || sda_low);

  adcc_top #(.CONV_CYCLES(CONV)) DUT (.i_core_clk(clk), .i_rst_b(rst_b), .i_scl(scl), .i_sda(sda),
    .o_sda_out(sda_out), .o_sda_oe(sda_oe), .i_addr_sel(addr_sel), .i_conv_raw(raw), .o_conv_run(run),
    .o_pos_input(pos), .o_neg_input(neg), .o_neg_ground(gnd));
  adcc_i2c_master m (.i_core_clk(clk), .i_sda(sda), .o_scl(scl), .o_sda_low(sda_low));

  // 40 MHz core clock
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end

  task automatic cmp(input logic [15:0] got, input logic [15:0] exp);
    compares++;
    if (got !== exp) begin
      num_errors++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic print_verdict();
    $display("errors %0d compares %0d", num_errors, compares);
    if (num_errors == 0 && compares > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  // Write frame: address, pointer if n > 1, two data bytes if n > 2; ak is high if the address or pointer byte went unanswered
  task automatic wr(input logic [7:0] a, input logic [7:0] p, input logic [15:0] d, input int n, output logic ak);
    logic [7:0] r;
    logic x;
    m.start();
    m.byte_io(a, 1'b1, r, ak);
    if (n > 1) begin
      m.byte_io(p, 1'b1, r, x);
      ak = ak | x;
    end
    if (n > 2) begin
      m.byte_io(d[15:8], 1'b1, r, x);
      m.byte_io(d[7:0], 1'b1, r, x);
    end
    m.stop();
  endtask

  task automatic rd(output logic [15:0] w);
    logic x;
    m.start();
    m.byte_io(8'h91, 1'b1, w[7:0], x);
    cmp({15'h0, x}, 16'h0);
    m.byte_io(8'hFF, 1'b0, w[15:8], x);
    m.byte_io(8'hFF, 1'b1, w[7:0], x);
    m.stop();
  endtask

  task automatic rd_ptr(input logic [7:0] p, output logic [15:0] w);
    logic ak;
    wr(8'h90, p, 16'h0, 2, ak);
    rd(w);
  endtask

  // Wait, bounded, for the running conversion to finish
  task automatic wait_idle();
    for (int n = 0; n < 2 * CONV && run === 1'b1; n++) begin
      @(negedge clk);
    end
    cmp({15'h0, run}, 16'h0);
  endtask

  task automatic t_reset();
    logic [15:0] w;
    rd(w);
    cmp(w, 16'h0000);
    rd_ptr(8'h01, w);
    cmp(w, 16'h8583);
    cmp({11'h0, pos, neg, gnd}, 16'h0002);
  endtask

  // Every selector code, six with a clip boundary or extreme on the raw word, two in range
  task automatic t_modes();
    logic [15:0] w;
    logic ak;
    logic signed [17:0] rv [8] = '{18'sh07FFF, 18'sh08000, 18'sh3FFFF, 18'sh38000, 18'sh37FFF, 18'sh1FFFF,
      18'sh20000, 18'sh01234};
    logic [15:0] ex [8] = '{16'h7FFF, 16'h7FFF, 16'hFFFF, 16'h8000, 16'h8000, 16'h7FFF, 16'h8000, 16'h1234};
    logic [4:0] mx [8] = '{5'h02, 5'h06, 5'h0E, 5'h16, 5'h01, 5'h09, 5'h11, 5'h19};
    for (int i = 0; i < 8; i++) begin
      raw = rv[i];
      wr(8'h90, 8'h01, {1'b1, i[2:0], 4'h1, 8'h83}, 4, ak);
      wait_idle();
      cmp({11'h0, pos, neg, gnd}, {11'h0, mx[i]});
      rd_ptr(8'h00, w);
      cmp(w, ex[i]);
    end
  endtask

  // Status bit low while busy, high after; retrigger while busy ignored
  task automatic t_status();
    logic [15:0] w;
    logic ak;
    int c0;
    raw = 18'sh00ABC;
    wr(8'h90, 8'h01, 16'hC583, 4, ak);
    c0 = cyc;
    cmp({15'h0, ak}, 16'h0);
    rd(w);
    cmp(w, 16'h4583);
    wr(8'h90, 8'h01, 16'hC583, 4, ak);
    wait_idle();
    cmp({15'h0, (cyc - c0) <= CONV}, 16'h1);
    repeat (CONV) @(negedge clk);
    cmp({15'h0, run}, 16'h0);
    rd(w);
    cmp(w, 16'hC583);
    rd_ptr(8'h00, w);
    cmp(w, 16'h0ABC);
  endtask

  task automatic t_cont();
    logic [15:0] w;
    logic ak;
    int hi;
    raw = 18'sh00111;
    wr(8'h90, 8'h01, 16'h0483, 4, ak);
    hi = 0;
    for (int n = 0; n < 3 * CONV; n++) begin
      @(negedge clk);
      hi += (run === 1'b1);
    end
    cmp({15'h0, hi == 3 * CONV}, 16'h1);
    raw = 18'sh00222;
    repeat (CONV + 5) @(negedge clk);
    rd_ptr(8'h00, w);
    cmp(w, 16'h0222);
    wr(8'h90, 8'h01, 16'h0583, 4, ak);
    repeat (CONV + 10) @(negedge clk);
    cmp({15'h0, run}, 16'h0);
  endtask

  // Foreign address ignored whole; selected address follows the pins
  task automatic t_addr();
    logic [15:0] w;
    logic ak;
    wr(8'h92, 8'h01, 16'h1234, 4, ak);
    cmp({15'h0, ak}, 16'h1);
    addr_sel = 2'h3;
    wr(8'h96, 8'h01, 16'h0, 2, ak);
    cmp({15'h0, ak}, 16'h0);
    addr_sel = 2'h0;
    rd_ptr(8'h01, w);
    cmp(w, 16'h8583);
  endtask

  task automatic t_gcall();
    logic [15:0] w;
    logic ak;
    wr(8'h90, 8'h01, 16'h3583, 4, ak);
    cmp({11'h0, pos, neg, gnd}, 16'h0016);
    wr(8'h00, 8'h06, 16'h0, 2, ak);
    cmp({15'h0, ak}, 16'h0);
    rd(w);
    cmp(w, 16'h0000);
    rd_ptr(8'h01, w);
    cmp(w, 16'h8583);
    cmp({11'h0, pos, neg, gnd}, 16'h0002);
  endtask

  // Hang guard well above the expected run length
  always @(posedge clk) begin
    cyc++;
    if (cyc == 100000) begin
      num_errors++;
      print_verdict();
    end
  end

  initial begin
    rst_b = 1'b0;
    addr_sel = 2'h0;
    raw = 18'sh0;
    repeat (10) @(negedge clk);
    rst_b = 1'b1;
    repeat (2) @(negedge clk);
    t_reset();
    t_modes();
    t_status();
    t_cont();
    t_addr();
    t_gcall();
    print_verdict();
  end
endmodule
